// ===== include/cpuod_pkg.sv
// Constants and types for the operand and instruction decode subset
`default_nettype none
package cpuod_pkg;
  localparam logic [7:0]  JUMP_UNCOND_OP = 8'h8B;
  localparam logic [3:0]  JUMP_LOW_NIB   = 4'hB;
  localparam logic [7:0]  SUB_SHORT_LO   = 8'h32;
  localparam logic [7:0]  SUB_SHORT_HI   = 8'h37;
  localparam logic [7:0]  SUB_EXT_LO     = 8'h38;
  localparam logic [7:0]  SUB_EXT_HI     = 8'h39;
  localparam logic [15:0] PC_RESET       = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  // Flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  // Condition codes; the upper eight are the inverses of the lower eight
  localparam logic [3:0] COND_F   = 4'h0;
  localparam logic [3:0] COND_LT  = 4'h1;
  localparam logic [3:0] COND_LE  = 4'h2;
  localparam logic [3:0] COND_ULE = 4'h3;
  localparam logic [3:0] COND_OV  = 4'h4;
  localparam logic [3:0] COND_MI  = 4'h5;
  localparam logic [3:0] COND_Z   = 4'h6;
  localparam logic [3:0] COND_C   = 4'h7;
  localparam logic [3:0] COND_T   = 4'h8;

  typedef enum logic [3:0] {
    CPUOD_KIND_NONE = 4'b0001,
    CPUOD_KIND_JMP  = 4'b0010,
    CPUOD_KIND_SUB  = 4'b0100,
    CPUOD_KIND_PASS = 4'b1000
  } cpuod_kind_e;
endpackage : cpuod_pkg
`default_nettype wire

// ===== core/cpuod_decode.sv
// Operand decode, relative jumps and subtract-with-borrow for the CPU subset
// Summary of operation
// RULE1 - The relative offset is a signed byte added to the address of the next instruction to form the new PC.
// RULE2 - Opcode 8B jumps always and opcodes 0B through FB jump only when their condition test is true.
// RULE3 - A bit-select operand is three bits wide and names bit zero through seven.
// RULE4 - Working register pair operands name only even indices zero to fourteen, an aligned pair.
// RULE5 - Plain and indirect register operands decode as an 8-bit index 00H to FFH.
// RULE6 - A wide file index decodes as a 12-bit register-file index 000H to FFFH.
// RULE7 - A register pair index is an even 8-bit index 00H to FEH addressing two consecutive bytes.
// RULE8 - A direct address operand carries a full 16-bit program address used as jump target.
// RULE9 - A literal byte is one byte from the instruction stream with any value.
// RULE10 - A polarity operand is a single bit, zero or one.
// RULE11 - Subtract with borrow writes dst minus src minus carry, computes C Z S V H and forces D to one.
// RULE12 - Flags are computed, kept, left undefined or forced per instruction encoding.
// RULE13 - Opcodes outside the subset pass on unchanged without touching flags or PC here.
`timescale 1ns/1ps
`default_nettype none
module cpuod_decode
  import cpuod_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  operand1_i,
  input  wire logic [7:0]  operand2_i,
  input  wire logic [7:0]  operand3_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic [7:0]  dst_data_i,
  input  wire logic [7:0]  src_data_i,
  input  wire logic [7:0]  flags_i,
  output logic             pc_load_o,
  output logic [15:0]      pc_value_o,
  output logic             result_valid_o,
  output logic [7:0]       result_o,
  output logic [7:0]       flags_o,
  output logic             fwd_valid_o,
  output logic [7:0]       fwd_opcode_o,
  output logic [2:0]       bit_sel_o,
  output logic [3:0]       work_pair_o,
  output logic [7:0]       reg_index_o,
  output logic [11:0]      wide_index_o,
  output logic [7:0]       pair_index_o,
  output logic [15:0]      direct_addr_o,
  output logic [7:0]       literal_o,
  output logic             polarity_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic cond_true(input logic [3:0] test_code, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic r;
    c = f[FLAG_C];
    z = f[FLAG_Z];
    s = f[FLAG_S];
    v = f[FLAG_V];
    case (test_code[2:0])
      COND_F[2:0]:   r = 1'b0;
      COND_LT[2:0]:  r = s ^ v;
      COND_LE[2:0]:  r = z | (s ^ v);
      COND_ULE[2:0]: r = c | z;
      COND_OV[2:0]:  r = v;
      COND_MI[2:0]:  r = s;
      COND_Z[2:0]:   r = z;
      COND_C[2:0]:   r = c;
      default:       r = 1'b0;
    endcase
    // Upper half of the codes is the inverse of the lower half
    return test_code[3] ? ~r : r;
  endfunction : cond_true

  function automatic logic is_subtract(input logic [7:0] op);
    return (op >= SUB_SHORT_LO) && (op <= SUB_EXT_HI);
  endfunction : is_subtract

  ////////////////////////////////////////////////////////////////////////////
  // Execute
  cpuod_kind_e kind_q, kind_d;
  logic        pc_load_q, pc_load_d;
  logic [15:0] pc_value_q, pc_value_d;
  logic        result_valid_q, result_valid_d;
  logic [7:0]  result_q, result_d;
  logic [7:0]  flags_q, flags_d;
  logic        fwd_valid_q, fwd_valid_d;
  logic [7:0]  fwd_opcode_q, fwd_opcode_d;
  logic [2:0]  bit_sel_q, bit_sel_d;
  logic [3:0]  work_pair_q, work_pair_d;
  logic [7:0]  reg_index_q, reg_index_d;
  logic [11:0] wide_index_q, wide_index_d;
  logic [7:0]  pair_index_q, pair_index_d;
  logic [15:0] direct_addr_q, direct_addr_d;
  logic [7:0]  literal_q, literal_d;
  logic        polarity_q, polarity_d;

  logic [8:0]  diff;
  logic [4:0]  half;
  logic        is_jmp;
  logic        is_sub;

  always_comb begin
    kind_d         = CPUOD_KIND_NONE;
    pc_load_d      = 1'b0;
    pc_value_d     = pc_value_q;
    result_valid_d = 1'b0;
    result_d       = result_q;
    flags_d        = flags_q;
    fwd_valid_d    = 1'b0;
    fwd_opcode_d   = fwd_opcode_q;
    // RULE3 bit select field
    bit_sel_d      = operand1_i[3:1];
    // RULE4 aligned working pair
    work_pair_d    = {operand1_i[3:1], 1'b0};
    // RULE5 8-bit register index
    reg_index_d    = operand1_i;
    // RULE6 12-bit wide index
    wide_index_d   = {operand1_i[3:0], operand2_i};
    // RULE7 even pair index
    pair_index_d   = {operand1_i[7:1], 1'b0};
    // RULE8 full direct address
    direct_addr_d  = {operand1_i, operand2_i};
    // RULE9 literal byte passthrough
    literal_d      = operand2_i;
    // RULE10 single polarity bit
    polarity_d     = operand1_i[0];
    is_jmp         = (opcode_i[3:0] == JUMP_LOW_NIB);
    is_sub         = is_subtract(opcode_i);
    // RULE11 dst minus src minus carry
    diff = {1'b0, dst_data_i} - {1'b0, src_data_i} - {8'h00, flags_i[FLAG_C]};
    half = {1'b0, dst_data_i[3:0]} - {1'b0, src_data_i[3:0]} - {4'h0, flags_i[FLAG_C]};
    if (instr_valid_i) begin
      if (is_jmp) begin
        kind_d = CPUOD_KIND_JMP;
        // RULE2 unconditional or tested jump
        if ((opcode_i == JUMP_UNCOND_OP) || cond_true(opcode_i[7:4], flags_i)) begin
          pc_load_d  = 1'b1;
          // RULE1 signed offset from next PC
          pc_value_d = next_pc_i + {{8{operand1_i[7]}}, operand1_i};
        end
      end else if (is_sub) begin
        kind_d         = CPUOD_KIND_SUB;
        result_valid_d = 1'b1;
        result_d       = diff[7:0];
        // RULE12 computed, forced and kept flags
        flags_d              = flags_i;
        flags_d[FLAG_C]      = diff[8];
        flags_d[FLAG_Z]      = (diff[7:0] == 8'h00);
        flags_d[FLAG_S]      = diff[7];
        flags_d[FLAG_V]      = (dst_data_i[7] ^ src_data_i[7]) & (dst_data_i[7] ^ diff[7]);
        flags_d[FLAG_D]      = 1'b1;
        flags_d[FLAG_H]      = half[4];
      end else begin
        // RULE13 forward unknown opcodes
        kind_d       = CPUOD_KIND_PASS;
        fwd_valid_d  = 1'b1;
        fwd_opcode_d = opcode_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      kind_q         <= CPUOD_KIND_NONE;
      pc_load_q      <= 1'b0;
      pc_value_q     <= PC_RESET;
      result_valid_q <= 1'b0;
      result_q       <= 8'h00;
      flags_q        <= FLAGS_RESET;
      fwd_valid_q    <= 1'b0;
      fwd_opcode_q   <= 8'h00;
      bit_sel_q      <= 3'h0;
      work_pair_q    <= 4'h0;
      reg_index_q    <= 8'h00;
      wide_index_q   <= 12'h000;
      pair_index_q   <= 8'h00;
      direct_addr_q  <= 16'h0000;
      literal_q      <= 8'h00;
      polarity_q     <= 1'b0;
    end else begin
      kind_q         <= kind_d;
      pc_load_q      <= pc_load_d;
      pc_value_q     <= pc_value_d;
      result_valid_q <= result_valid_d;
      result_q       <= result_d;
      flags_q        <= flags_d;
      fwd_valid_q    <= fwd_valid_d;
      fwd_opcode_q   <= fwd_opcode_d;
      bit_sel_q      <= bit_sel_d;
      work_pair_q    <= work_pair_d;
      reg_index_q    <= reg_index_d;
      wide_index_q   <= wide_index_d;
      pair_index_q   <= pair_index_d;
      direct_addr_q  <= direct_addr_d;
      literal_q      <= literal_d;
      polarity_q     <= polarity_d;
    end
  end

  assign pc_load_o      = pc_load_q;
  assign pc_value_o     = pc_value_q;
  assign result_valid_o = result_valid_q;
  assign result_o       = result_q;
  assign flags_o        = flags_q;
  assign fwd_valid_o    = fwd_valid_q;
  assign fwd_opcode_o   = fwd_opcode_q;
  assign bit_sel_o      = bit_sel_q;
  assign work_pair_o    = work_pair_q;
  assign reg_index_o    = reg_index_q;
  assign wide_index_o   = wide_index_q;
  assign pair_index_o   = pair_index_q;
  assign direct_addr_o  = direct_addr_q;
  assign literal_o      = literal_q;
  assign polarity_o     = polarity_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_jump_uncond;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (instr_valid_i && opcode_i == JUMP_UNCOND_OP) |=> pc_load_o && kind_q == CPUOD_KIND_JMP;
  endproperty
  a_jump_uncond: assert property (p_jump_uncond) else $error("unconditional jump not taken"); // RULE2

  // Code zero never branches, so the flags must not matter at all here
  property p_jump_never;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (instr_valid_i && opcode_i == {COND_F, JUMP_LOW_NIB}) |=> !pc_load_o && kind_q == CPUOD_KIND_JMP;
  endproperty
  a_jump_never: assert property (p_jump_never) else $error("never-taken jump loaded the PC"); // RULE2

  property p_jump_target;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (instr_valid_i && opcode_i == JUMP_UNCOND_OP)
      |=> pc_value_o == $past(next_pc_i) + {{8{$past(operand1_i[7])}}, $past(operand1_i)};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong"); // RULE1

  property p_pc_only_jump;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    pc_load_o |-> $past(instr_valid_i) && $past(opcode_i[3:0]) == JUMP_LOW_NIB && kind_q == CPUOD_KIND_JMP;
  endproperty
  a_pc_only_jump: assert property (p_pc_only_jump) else $error("PC loaded by non-jump"); // RULE13

  property p_sub_result;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (instr_valid_i && is_subtract(opcode_i))
      |=> result_valid_o && kind_q == CPUOD_KIND_SUB
        && result_o == 8'($past(dst_data_i) - $past(src_data_i) - {7'h00, $past(flags_i[FLAG_C])});
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("subtract result wrong"); // RULE11

  // Borrows are stated as comparisons so that a wrong carry chain cannot agree with itself
  property p_sub_borrow;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (instr_valid_i && is_subtract(opcode_i))
      |=> flags_o[FLAG_C] == ({1'b0, $past(dst_data_i)}
                               < {1'b0, $past(src_data_i)} + {8'h00, $past(flags_i[FLAG_C])})
        && flags_o[FLAG_H] == ({1'b0, $past(dst_data_i[3:0])}
                               < {1'b0, $past(src_data_i[3:0])} + {4'h0, $past(flags_i[FLAG_C])})
        && flags_o[FLAG_V] == (($past(dst_data_i[7]) != $past(src_data_i[7]))
                               && (result_o[7] != $past(dst_data_i[7])));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow or overflow flag wrong"); // RULE11

  property p_sub_flags;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    result_valid_o |-> flags_o[FLAG_D] && (flags_o[FLAG_Z] == (result_o == 8'h00)) && flags_o[FLAG_S] == result_o[7];
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong"); // RULE12

  property p_fwd;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    fwd_valid_o |-> fwd_opcode_o == $past(opcode_i) && $stable(flags_o) && !pc_load_o && kind_q == CPUOD_KIND_PASS;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded opcode altered state"); // RULE13

  property p_pair_even;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    1'b1 |=> work_pair_o == {$past(operand1_i[3:1]), 1'b0} && pair_index_o == {$past(operand1_i[7:1]), 1'b0};
  endproperty
  a_pair_even: assert property (p_pair_even) else $error("pair index not aligned"); // RULE4

  property p_fields;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    1'b1 |=> bit_sel_o == $past(operand1_i[3:1]) && reg_index_o == $past(operand1_i)
      && literal_o == $past(operand2_i) && polarity_o == $past(operand1_i[0]);
  endproperty
  a_fields: assert property (p_fields) else $error("operand field wrong"); // RULE3

  property p_wide;
    @(posedge core_clk_i) disable iff (!rst_n_q)
    1'b1 |=> wide_index_o == {$past(operand1_i[3:0]), $past(operand2_i)}
      && direct_addr_o == {$past(operand1_i), $past(operand2_i)};
  endproperty
  a_wide: assert property (p_wide) else $error("wide index wrong"); // RULE6

endmodule : cpuod_decode
`default_nettype wire

// ===== tb/cpuod_fetch_model.sv
// Fetch-side model: tracks the program counter that the decode block redirects
`timescale 1ns/1ps
`default_nettype none
module cpuod_fetch_model (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic        pc_load_i,
  input  wire logic [15:0] pc_value_i,
  output logic [15:0]      next_pc_o
);
  logic [15:0] pc_q;
  // Each modelled instruction is two bytes long, so the follower sits at pc plus two
  assign next_pc_o = pc_q + 16'h0002;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_q <= 16'h0100;
    end else if (pc_load_i) begin
      pc_q <= pc_value_i;
    end else if (instr_valid_i) begin
      pc_q <= next_pc_o;
    end
  end
endmodule : cpuod_fetch_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the operand and instruction decode subset
`timescale 1ns/1ps
`default_nettype none
module tb
  import cpuod_pkg::*;
;
  typedef struct {int kind; logic [7:0] op, o1, o2, res, fl; logic [15:0] tgt;} cpuod_note_s;
  logic clk = 1'b0, arst_n = 1'b0, vld = 1'b0, v_q = 1'b0;
  logic [7:0] op = '0, o1 = '0, o2 = '0, dd = '0, ss = '0, fi = '0, last_fl = FLAGS_RESET;
  logic pc_load, res_v, fwd_v, pol;
  logic [15:0] pc_val, npc, daddr;
  logic [7:0] res, fl_o, fwd_op, rix, pix, lit;
  logic [2:0] bsel;
  logic [3:0] wpair;
  logic [11:0] widx;
  logic [7:0] jmp_offs [4] = '{8'h7F, 8'h80, 8'hFE, 8'h00};
  int n_errors = 0, checked = 0;
  cpuod_note_s q[$];
  always #50 clk = ~clk;
  cpuod_decode cpuod_decode_i (.core_clk_i(clk), .arst_n_i(arst_n), .instr_valid_i(vld), .opcode_i(op),
    .operand1_i(o1), .operand2_i(o2), .operand3_i(8'h00), .next_pc_i(npc), .dst_data_i(dd), .src_data_i(ss),
    .flags_i(fi), .pc_load_o(pc_load), .pc_value_o(pc_val), .result_valid_o(res_v), .result_o(res),
    .flags_o(fl_o), .fwd_valid_o(fwd_v), .fwd_opcode_o(fwd_op), .bit_sel_o(bsel), .work_pair_o(wpair),
    .reg_index_o(rix), .wide_index_o(widx), .pair_index_o(pix), .direct_addr_o(daddr), .literal_o(lit),
    .polarity_o(pol));
  cpuod_fetch_model cpuod_fetch_model_i (.core_clk_i(clk), .arst_n_i(arst_n), .instr_valid_i(vld),
    .pc_load_i(pc_load), .pc_value_i(pc_val), .next_pc_o(npc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  function automatic logic cond(input logic [3:0] test_code, input logic [7:0] f);
    logic t;
    case (test_code[2:0])
      3'd1: t = f[FLAG_S] ^ f[FLAG_V];
      3'd2: t = f[FLAG_Z] | (f[FLAG_S] ^ f[FLAG_V]);
      3'd3: t = f[FLAG_C] | f[FLAG_Z];
      3'd4: t = f[FLAG_V];
      3'd5: t = f[FLAG_S];
      3'd6: t = f[FLAG_Z];
      3'd7: t = f[FLAG_C];
      default: t = 1'b0;
    endcase
    return test_code[3] ? ~t : t;
  endfunction : cond
  function automatic logic [7:0] rnd8();
    return 8'($urandom);
  endfunction : rnd8
  // Drive one instruction at the falling edge and note what must come back
  task automatic issue(input logic [7:0] opc, a, b, d, s, f);
    cpuod_note_s n;
    logic [8:0] r;
    @(negedge clk);
    n = '{3, opc, a, b, 8'h00, 8'h00, 16'h0000};
    if (opc[3:0] == JUMP_LOW_NIB) begin
      n.kind = cond(opc[7:4], f) ? 0 : 1;
      n.tgt = npc + {{8{a[7]}}, a};
    end else if (opc >= SUB_SHORT_LO && opc <= SUB_EXT_HI) begin
      r = {1'b0, d} - {1'b0, s} - {8'h00, f[FLAG_C]};
      n.kind = 2;
      n.res = r[7:0];
      n.fl = {r[8], r[7:0] == 8'h00, r[7], (d[7] != s[7]) && (r[7] != d[7]), 1'b1,
              {1'b0, d[3:0]} < ({1'b0, s[3:0]} + {4'h0, f[FLAG_C]}), 2'b00};
    end
    {vld, op, o1, o2, dd, ss, fi} = {1'b1, opc, a, b, d, s, f};
    q.push_back(n);
  endtask : issue
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) v_q <= vld;
  always @(negedge clk) begin
    cpuod_note_s n;
    if (v_q && q.size() == 0) begin
      n_errors++;
      $display("MISMATCH note_queue expected 1 seen 0");
    end else if (v_q) begin
      n = q.pop_front();
      chk("bit_sel", {13'h0, n.o1[3:1]}, {13'h0, bsel});
      chk("work_pair", {12'h0, n.o1[3:1], 1'b0}, {12'h0, wpair});
      chk("reg_index", {8'h0, n.o1}, {8'h0, rix});
      chk("wide_index", {4'h0, n.o1[3:0], n.o2}, {4'h0, widx});
      chk("pair_index", {8'h0, n.o1[7:1], 1'b0}, {8'h0, pix});
      chk("direct_addr", {n.o1, n.o2}, daddr);
      chk("literal", {8'h0, n.o2}, {8'h0, lit});
      chk("polarity", {15'h0, n.o1[0]}, {15'h0, pol});
      chk("pc_load", {15'h0, n.kind == 0}, {15'h0, pc_load});
      if (n.kind == 0) chk("pc_value", n.tgt, pc_val);
      chk("result_valid", {15'h0, n.kind == 2}, {15'h0, res_v});
      if (n.kind == 2) begin
        last_fl = n.fl;
        chk("result", {8'h0, n.res}, {8'h0, res});
      end
      chk("flags", {10'h0, last_fl[7:2]}, {10'h0, fl_o[7:2]});
      chk("fwd_valid", {15'h0, n.kind == 3}, {15'h0, fwd_v});
      if (n.kind == 3) begin
        chk("fwd_opcode", {8'h0, n.op}, {8'h0, fwd_op});
      end
    end
  end
  initial begin
    #(100 * 60000);
    n_errors++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] x;
    void'($urandom(32'hD1944D0C));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    // Offset extremes, then every condition code back to back
    foreach (jmp_offs[i]) issue(JUMP_UNCOND_OP, jmp_offs[i], 8'hFF, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 64; i++) begin
      issue({i[3:0], JUMP_LOW_NIB}, rnd8(), rnd8(), 8'h00, 8'h00, rnd8());
    end
    // Every subtract form, with corner operands first
    issue(SUB_SHORT_LO, 8'h01, 8'h02, 8'h10, 8'h01, 8'h80);
    issue(SUB_EXT_HI, 8'hFF, 8'hFF, 8'h80, 8'h01, 8'h00);
    issue(SUB_SHORT_HI, 8'h0E, 8'h00, 8'h00, 8'h00, 8'h80);
    for (int i = 0; i < 80; i++) begin
      issue(8'(SUB_SHORT_LO + i % 8), rnd8(), rnd8(), rnd8(), rnd8(), rnd8());
    end
    // Opcodes outside the subset must pass through without touching flags or pc
    for (int i = 0; i < 80; i++) begin
      x = rnd8();
      if (x[3:0] != JUMP_LOW_NIB && (x < SUB_SHORT_LO || x > SUB_EXT_HI)) begin
        issue(x, rnd8(), rnd8(), rnd8(), rnd8(), rnd8());
      end
    end
    @(negedge clk);
    vld = 1'b0;
    repeat (3) @(negedge clk);
    chk("note_queue", 16'h0, 16'(q.size()));
    print_verdict();
  end
endmodule : tb
`default_nettype wire
